// ===== sswd_defs.svh
`ifndef SSWD_DEFS_SVH
`define SSWD_DEFS_SVH
// Clock period in picoseconds (40 MHz)
`define SSWD_CLK_PERIOD_PS 25000
// Hold after supply good or manual/watchdog reset, in ms (nominal)
`define SSWD_HOLD_TIME_MS 200
// Watchdog timeout in ms (nominal)
`define SSWD_WDOG_TIME_MS 1600
// Glitch reject width in ns; longest time, rounded down, at least one cycle
`define SSWD_SPIKE_NS 30
// Host wait after power-up before memory access, in ms
`define SSWD_HOST_WAIT_MS 270
// Cycle counts derived from the times
`define SSWD_HOLD_CYCLES (`SSWD_HOLD_TIME_MS * 40000)
`define SSWD_WDOG_CYCLES (`SSWD_WDOG_TIME_MS * 40000)
`define SSWD_SPIKE_CYCLES_RAW ((`SSWD_SPIKE_NS * 1000) / `SSWD_CLK_PERIOD_PS)
`define SSWD_SPIKE_CYCLES \
  ((`SSWD_SPIKE_CYCLES_RAW < 1) ? 1 : `SSWD_SPIKE_CYCLES_RAW)
`define SSWD_HOST_WAIT_CYCLES (`SSWD_HOST_WAIT_MS * 40000)
// Internal memory write cycle in ms, and its length in cycles
`define SSWD_WRITE_TIME_MS 5
`define SSWD_WRITE_CYCLES (`SSWD_WRITE_TIME_MS * 40000)
// Host serial clock half period in cycles, less one (each phase lasts this plus one)
`define SSWD_HALF_CYCLES 64
// Synchroniser reset levels: sda, scl idle high; kick, pin, aux, supply low
`define SSWD_SYNC_RST 6'h30
`endif

// ===== sswd_pkg.sv
package sswd_pkg;
  typedef enum logic [2:0] {
    SSWD_ST_HOLD = 3'b001,
    SSWD_ST_RUN = 3'b010,
    SSWD_ST_TRIP = 3'b100
  } sswd_state_e;
  typedef enum logic [2:0] {
    SSWD_MEM_IDLE = 3'b001,
    SSWD_MEM_BUSY = 3'b010,
    SSWD_MEM_PROG = 3'b100
  } sswd_mem_e;
endpackage : sswd_pkg

// ===== sswd_if.sv
`timescale 1ns/10ps
interface sswd_if;
  // Reset pin, open drain: oe low while the supervisor pulls it low
  logic rst_pin_oe_n;
  logic rst_pin_host_oe_n;
  logic rst_pin_level;
  // Auxiliary flag, open drain
  logic aux_flag_oe_n;
  logic watchdog_kick;
  // Serial memory bus, open drain; clock from the host only, data both ends
  logic scl_host_oe_n;
  logic sda_host_oe_n;
  logic sda_dev_oe_n;
  logic scl_level;
  logic sda_level;
  assign rst_pin_level = rst_pin_oe_n & rst_pin_host_oe_n;
  assign scl_level = scl_host_oe_n;
  assign sda_level = sda_host_oe_n & sda_dev_oe_n;
  modport device (
    output rst_pin_oe_n, aux_flag_oe_n, sda_dev_oe_n,
    input rst_pin_level, watchdog_kick, scl_level, sda_level
  );
  modport host (
    output rst_pin_host_oe_n, watchdog_kick, scl_host_oe_n, sda_host_oe_n,
    input rst_pin_level, aux_flag_oe_n, scl_level, sda_level
  );
endinterface : sswd_if

// ===== sswd_device.sv
`timescale 1ns/10ps
`include "sswd_defs.svh"
module sswd_device #(
  parameter int unsigned HOLD_CYCLES = `SSWD_HOLD_CYCLES,
  parameter int unsigned WDOG_CYCLES = `SSWD_WDOG_CYCLES,
  parameter int unsigned SPIKE_CYCLES = `SSWD_SPIKE_CYCLES,
  parameter int unsigned WRITE_CYCLES = `SSWD_WRITE_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic supply_ok_in,
  input wire logic aux_ok_in,
  input wire logic mem_write_req_in,
  output logic reset_active_out,
  output logic reset_high_out,
  output logic mem_enable_out,
  output logic mem_write_busy_out,
  output logic wdog_fired_out,
  sswd_if.device link
);
  import sswd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: supply, aux, reset pin, kick, bus lines
  localparam int NSYNC = 6;
  // Reset to the level each line shows in reset, so no false edge follows
  localparam logic [NSYNC-1:0] SYNC_RST = `SSWD_SYNC_RST;
  logic [NSYNC-1:0] raw_w;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  assign raw_w = {link.sda_level, link.scl_level, link.watchdog_kick,
                  link.rst_pin_level, aux_ok_in, supply_ok_in};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
          s1_q[gi] <= SYNC_RST[gi];
          s2_q[gi] <= SYNC_RST[gi];
        end else begin
          s1_q[gi] <= raw_w[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate
  logic supply_s, aux_s, pin_s, kick_s, scl_s, sda_s;
  assign supply_s = s2_q[0];
  assign aux_s = s2_q[1];
  assign pin_s = s2_q[2];
  assign kick_s = s2_q[3];
  assign scl_s = s2_q[4];
  assign sda_s = s2_q[5];

  ////////////////////////////////////////////////////////////////////////////
  // Supply glitch filter: a low no longer than the reject width is ignored
  logic [7:0] low_cnt_q;
  logic supply_bad_q;
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      low_cnt_q <= 8'h00;
      supply_bad_q <= 1'b1;
    end else if (supply_s) begin
      low_cnt_q <= 8'h00;
      supply_bad_q <= 1'b0;
    end else if (low_cnt_q >= 8'(SPIKE_CYCLES)) begin
      supply_bad_q <= 1'b1;
    end else begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer
  sswd_state_e state_q;
  logic [31:0] hold_q;
  logic [31:0] wdog_q;
  logic pin_d1_q, kick_d1_q;
  logic manual_edge, kick_edge, wdog_expire;
  // Own drive also makes a falling edge; ignore it by looking only in RUN
  assign manual_edge = pin_d1_q & ~pin_s;
  assign kick_edge = kick_d1_q ^ kick_s;
  assign wdog_expire = (wdog_q >= WDOG_CYCLES - 1);
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      pin_d1_q <= 1'b0;
      kick_d1_q <= 1'b0;
    end else begin
      pin_d1_q <= pin_s;
      kick_d1_q <= kick_s;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state_q <= SSWD_ST_HOLD;
      hold_q <= 32'h0000_0000;
    end else if (supply_bad_q) begin
      state_q <= SSWD_ST_HOLD;
      hold_q <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        SSWD_ST_HOLD: begin
          // Counts from start of hold, so short manual pulses get full time
          if (hold_q >= HOLD_CYCLES - 1) begin
            state_q <= SSWD_ST_RUN;
            hold_q <= 32'h0000_0000;
          end else begin
            hold_q <= hold_q + 32'h0000_0001;
          end
        end
        SSWD_ST_RUN: begin
          if (manual_edge) begin
            state_q <= SSWD_ST_HOLD;
            hold_q <= 32'h0000_0000;
          end else if (wdog_expire) begin
            state_q <= SSWD_ST_TRIP;
          end
        end
        SSWD_ST_TRIP: begin
          state_q <= SSWD_ST_HOLD;
          hold_q <= 32'h0000_0000;
        end
      endcase
    end
  end
  logic in_reset;
  assign in_reset = (state_q != SSWD_ST_RUN);

  // Watchdog counter
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || in_reset) begin
      wdog_q <= 32'h0000_0000;
    end else if (kick_edge) begin
      wdog_q <= 32'h0000_0000;
    end else if (!wdog_expire) begin
      wdog_q <= wdog_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      reset_active_out <= 1'b1;
      reset_high_out <= 1'b1;
      link.rst_pin_oe_n <= 1'b0;
      link.aux_flag_oe_n <= 1'b0;
      wdog_fired_out <= 1'b0;
    end else begin
      reset_active_out <= in_reset;
      reset_high_out <= in_reset;
      link.rst_pin_oe_n <= ~in_reset;
      link.aux_flag_oe_n <= aux_s;
      wdog_fired_out <= (state_q == SSWD_ST_TRIP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory gate: bus conditions and internal write cycle
  logic scl_d1_q, sda_d1_q;
  logic start_cond, stop_cond;
  // Data edge while clock high is START or STOP
  assign start_cond = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  assign stop_cond = scl_s & scl_d1_q & ~sda_d1_q & sda_s;
  sswd_mem_e mem_q;
  logic [31:0] wc_q;
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      mem_q <= SSWD_MEM_IDLE;
      wc_q <= 32'h0000_0000;
    end else begin
      unique case (mem_q)
        SSWD_MEM_IDLE: begin
          if (start_cond && !in_reset) begin
            mem_q <= SSWD_MEM_BUSY;
          end
        end
        SSWD_MEM_BUSY: begin
          if (in_reset) begin
            mem_q <= SSWD_MEM_IDLE;
          end else if (stop_cond && mem_write_req_in) begin
            mem_q <= SSWD_MEM_PROG;
            wc_q <= 32'h0000_0000;
          end else if (stop_cond) begin
            mem_q <= SSWD_MEM_IDLE;
          end
        end
        SSWD_MEM_PROG: begin
          // Running write finishes even under reset
          if (wc_q >= WRITE_CYCLES - 1) begin
            mem_q <= SSWD_MEM_IDLE;
          end else begin
            wc_q <= wc_q + 32'h0000_0001;
          end
        end
      endcase
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      mem_enable_out <= 1'b0;
      mem_write_busy_out <= 1'b0;
      link.sda_dev_oe_n <= 1'b1;
    end else begin
      mem_enable_out <= ~in_reset && (mem_q == SSWD_MEM_BUSY);
      mem_write_busy_out <= (mem_q == SSWD_MEM_PROG);
      link.sda_dev_oe_n <= 1'b1; // Data path of the memory lies elsewhere
    end
  end
endmodule : sswd_device

// ===== sswd_host.sv
`timescale 1ns/10ps
`include "sswd_defs.svh"
// Host end: waits after power-up, kicks the watchdog, pulses manual
// reset and frames serial memory START/STOP on an idle bus.
module sswd_host #(
  parameter int unsigned WAIT_CYCLES = `SSWD_HOST_WAIT_CYCLES,
  parameter int unsigned HALF_CYCLES = `SSWD_HALF_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic kick_toggle_in,
  input wire logic manual_req_in,
  input wire logic frame_req_in,
  output logic ready_out,
  output logic in_reset_out,
  output logic aux_low_out,
  output logic frame_busy_out,
  sswd_if.host link
);
  import sswd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic rs1_q, rs2_q, as1_q, as2_q, ss1_q, ss2_q;
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
      as1_q <= 1'b0;
      as2_q <= 1'b0;
      ss1_q <= 1'b1;
      ss2_q <= 1'b1;
    end else begin
      rs1_q <= link.rst_pin_level;
      rs2_q <= rs1_q;
      as1_q <= link.aux_flag_oe_n;
      as2_q <= as1_q;
      ss1_q <= link.sda_level;
      ss2_q <= ss1_q;
    end
  end

  // Wait after reset release before memory use
  logic [31:0] wait_q;
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || !rs2_q) begin
      wait_q <= 32'h0000_0000;
      ready_out <= 1'b0;
    end else if (wait_q >= WAIT_CYCLES - 1) begin
      ready_out <= 1'b1;
    end else begin
      wait_q <= wait_q + 32'h0000_0001;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      in_reset_out <= 1'b1;
      aux_low_out <= 1'b1;
      link.watchdog_kick <= 1'b0;
      link.rst_pin_host_oe_n <= 1'b1;
    end else begin
      in_reset_out <= ~rs2_q;
      aux_low_out <= ~as2_q;
      link.watchdog_kick <= link.watchdog_kick ^ kick_toggle_in;
      link.rst_pin_host_oe_n <= ~manual_req_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // START, two clocks, STOP; data moves only with clock high
  logic [3:0] ph_q;
  logic [15:0] tick_q;
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      ph_q <= 4'h0;
      tick_q <= 16'h0000;
      link.scl_host_oe_n <= 1'b1;
      link.sda_host_oe_n <= 1'b1;
      frame_busy_out <= 1'b0;
    end else if (ph_q == 4'h0) begin
      // Begin only on idle bus and when allowed
      if (frame_req_in && ready_out && ss2_q) begin
        ph_q <= 4'h1;
        frame_busy_out <= 1'b1;
        link.sda_host_oe_n <= 1'b0;
      end
    end else if (tick_q < 16'(HALF_CYCLES)) begin
      tick_q <= tick_q + 16'h0001;
    end else begin
      tick_q <= 16'h0000;
      ph_q <= ph_q + 4'h1;
      unique case (ph_q)
        4'h1: link.scl_host_oe_n <= 1'b0;
        4'h2: link.scl_host_oe_n <= 1'b1;
        4'h3: link.scl_host_oe_n <= 1'b0;
        4'h4: link.scl_host_oe_n <= 1'b1;
        4'h5: link.sda_host_oe_n <= 1'b1;
        default: begin
          ph_q <= 4'h0;
          frame_busy_out <= 1'b0;
        end
      endcase
    end
  end
endmodule : sswd_host

// ===== sswd_sva.sv
`timescale 1ns/10ps
module sswd_sva #(
  parameter int unsigned HOLD_CYCLES = 200,
  parameter int unsigned WDOG_CYCLES = 500,
  parameter int unsigned WAIT_CYCLES = 300
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic rst_pin_oe_n,
  input wire logic rst_pin_host_oe_n,
  input wire logic rst_pin_level,
  input wire logic watchdog_kick,
  input wire logic sda_dev_oe_n,
  input wire logic scl_level,
  input wire logic sda_level
);
  int unsigned lo_q;
  int unsigned hi_q;
  int unsigned idle_q;
  logic kick_q;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in) begin
    lo_q <= (!reset_n_in || rst_pin_oe_n) ? 0 : lo_q + 1;
  end
  always_ff @(posedge core_clk_in) begin
    hi_q <= (!reset_n_in || !rst_pin_level) ? 0 : hi_q + 1;
  end
  // Slack of six covers the kick synchroniser and the pin register
  always_ff @(posedge core_clk_in) begin
    kick_q <= watchdog_kick;
    if (!reset_n_in || !rst_pin_oe_n || watchdog_kick != kick_q) begin
      idle_q <= 0;
    end else begin
      idle_q <= idle_q + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_start;
    scl_level && $fell(sda_level);
  endsequence
  sequence s_stop;
    scl_level && $rose(sda_level);
  endsequence
  a_hold_min_len: assert property ($rose(rst_pin_oe_n) |->
    lo_q >= HOLD_CYCLES - 2) else $error("reset released too early");
  a_wdog_max_idle: assert property (idle_q <= WDOG_CYCLES + 6)
    else $error("watchdog did not trip in time");
  a_manual_edge_taken: assert property (
    $fell(rst_pin_host_oe_n) && rst_pin_oe_n |-> ##[1:8] !rst_pin_oe_n)
    else $error("manual reset edge ignored");
  a_start_on_idle: assert property (s_start |-> $past(scl_level))
    else $error("start on busy bus");
  a_host_waits: assert property (s_start |-> hi_q >= WAIT_CYCLES)
    else $error("memory access before wait");
  a_frame_clock: assert property (
    s_start |-> scl_level [*4] ##[1:4] !scl_level)
    else $error("bad clock after start");
  a_stop_idle_bus: assert property (
    s_stop |-> (scl_level && sda_level) [*4]) else $error("bus not idle");
  a_dev_sda_off: assert property (sda_dev_oe_n)
    else $error("device drove data line");
endmodule : sswd_sva

// ===== tb.sv
`timescale 1ns/10ps
module tb;
  localparam int HOLD = 200;
  localparam int WDOG = 500;
  localparam int WR = 50;
  localparam int WAIT = 300;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic supply_ok_in = 1'b0;
  logic aux_ok_in = 1'b1;
  logic mem_write_req_in = 1'b0;
  logic kick_toggle_in = 1'b0;
  logic manual_req_in = 1'b0;
  logic frame_req_in = 1'b0;
  logic kick_en = 1'b0;
  logic [6:0] kc = 7'h00;
  logic rst_act, rst_hi, mem_en, wr_busy, wd_fired;
  logic ready, in_rst, aux_low, fr_busy;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  sswd_if sswd_if_i ();
  sswd_device #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG), .SPIKE_CYCLES(1),
    .WRITE_CYCLES(WR)) sswd_device_i (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .supply_ok_in(supply_ok_in),
    .aux_ok_in(aux_ok_in), .mem_write_req_in(mem_write_req_in),
    .reset_active_out(rst_act), .reset_high_out(rst_hi),
    .mem_enable_out(mem_en), .mem_write_busy_out(wr_busy),
    .wdog_fired_out(wd_fired), .link(sswd_if_i));
  sswd_host #(.WAIT_CYCLES(WAIT), .HALF_CYCLES(4)) sswd_host_i (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .kick_toggle_in(kick_toggle_in), .manual_req_in(manual_req_in),
    .frame_req_in(frame_req_in), .ready_out(ready), .in_reset_out(in_rst),
    .aux_low_out(aux_low), .frame_busy_out(fr_busy), .link(sswd_if_i));
  sswd_sva #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG), .WAIT_CYCLES(WAIT))
    sswd_sva_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .rst_pin_oe_n(sswd_if_i.rst_pin_oe_n),
    .rst_pin_host_oe_n(sswd_if_i.rst_pin_host_oe_n),
    .rst_pin_level(sswd_if_i.rst_pin_level),
    .watchdog_kick(sswd_if_i.watchdog_kick),
    .sda_dev_oe_n(sswd_if_i.sda_dev_oe_n),
    .scl_level(sswd_if_i.scl_level), .sda_level(sswd_if_i.sda_level));
  always #12.5 core_clk_in = ~core_clk_in;
  // Kick every 128 cycles, well inside the watchdog period
  always @(posedge core_clk_in) begin
    kc <= kc + 7'h01;
    kick_toggle_in <= kick_en && kc == 7'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  function automatic logic sig(input int k);
    case (k)
      0: sig = rst_act;
      1: sig = wd_fired;
      2: sig = ready;
      3: sig = wr_busy;
      4: sig = mem_en;
      default: sig = aux_low;
    endcase
  endfunction : sig
  task automatic step(input int c);
    repeat (c) @(posedge core_clk_in);
    #1;
  endtask : step
  task automatic wait_sig(input int k, input logic v, input int lim);
    #1;
    n = 0;
    while (sig(k) !== v) begin
      step(1);
      n++;
      if (n > lim) begin
        n_mismatch++;
        $display("ERROR wait on output %0d ran out", k);
        print_verdict();
      end
    end
  endtask : wait_sig
  task automatic pulse_manual();
    @(posedge core_clk_in) manual_req_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    manual_req_in <= 1'b0;
  endtask : pulse_manual
  ////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    @(posedge core_clk_in) supply_ok_in <= 1'b1;
    step(1);
    chk("pin held", sswd_if_i.rst_pin_oe_n, 0);
    wait_sig(0, 1'b0, HOLD + 20);
    chk("hold time", n >= HOLD && n <= HOLD + 8, 1);
    step(2);
    chk("pin released", sswd_if_i.rst_pin_oe_n, 1);
    chk("high reset off", rst_hi, 0);
    step(2);
    chk("host sees release", in_rst, 0);
    $display("power-up test done");
  endtask : t_power
  task automatic t_glitch();
    @(posedge core_clk_in) supply_ok_in <= 1'b0;
    @(posedge core_clk_in) supply_ok_in <= 1'b1;
    step(10);
    chk("glitch ignored", rst_act, 0);
    @(posedge core_clk_in) supply_ok_in <= 1'b0;
    wait_sig(0, 1'b1, 20);
    chk("drop delay", n <= 8, 1);
    chk("high reset on", rst_hi, 1);
    @(posedge core_clk_in) supply_ok_in <= 1'b1;
    wait_sig(0, 1'b0, HOLD + 20);
    $display("supply drop test done");
  endtask : t_glitch
  task automatic t_aux();
    @(posedge core_clk_in) aux_ok_in <= 1'b0;
    wait_sig(5, 1'b1, 8);
    chk("aux flag low", sswd_if_i.aux_flag_oe_n, 0);
    @(posedge core_clk_in) aux_ok_in <= 1'b1;
    wait_sig(5, 1'b0, 8);
    chk("aux flag free", sswd_if_i.aux_flag_oe_n, 1);
    $display("aux test done");
  endtask : t_aux
  task automatic t_mem();
    wait_sig(2, 1'b1, WAIT + 50);
    @(posedge core_clk_in) frame_req_in <= 1'b1;
    mem_write_req_in <= 1'b1;
    wait_sig(4, 1'b1, 30);
    chk("frame running", fr_busy, 1);
    @(posedge core_clk_in) frame_req_in <= 1'b0;
    wait_sig(3, 1'b1, 40);
    // Reset lands in the write, which must still run its full length
    @(posedge core_clk_in) supply_ok_in <= 1'b0;
    wait_sig(3, 1'b0, WR + 10);
    chk("write length", n >= WR - 4 && n <= WR + 2, 1);
    chk("memory off", mem_en, 0);
    chk("frame over", fr_busy, 0);
    @(posedge core_clk_in) supply_ok_in <= 1'b1;
    wait_sig(2, 1'b1, HOLD + WAIT + 50);
    @(posedge core_clk_in) frame_req_in <= 1'b1;
    wait_sig(4, 1'b1, 30);
    pulse_manual();
    frame_req_in <= 1'b0;
    wait_sig(4, 1'b0, 10);
    step(40);
    chk("no write in reset", wr_busy, 0);
    @(posedge core_clk_in) mem_write_req_in <= 1'b0;
    wait_sig(0, 1'b0, HOLD + 20);
    $display("memory test done");
  endtask : t_mem
  task automatic t_manual();
    @(posedge core_clk_in) kick_en <= 1'b0;
    pulse_manual();
    wait_sig(0, 1'b1, 10);
    chk("host sees reset", in_rst, 1);
    wait_sig(0, 1'b0, HOLD + 20);
    chk("manual hold", n >= HOLD - 4 && n <= HOLD + 8, 1);
    $display("manual reset test done");
  endtask : t_manual
  task automatic t_wdog();
    for (int i = 0; i < 2; i++) begin
      wait_sig(1, 1'b1, WDOG + 20);
      chk("kick timeout", n >= WDOG - 4 && n <= WDOG + 4, 1);
      step(3);
      chk("watchdog reset", rst_act, 1);
      wait_sig(0, 1'b0, HOLD + 20);
      chk("watchdog hold", n >= HOLD - 4, 1);
    end
    @(posedge core_clk_in) kick_en <= 1'b1;
    n = 0;
    repeat (3 * WDOG) begin
      step(1);
      n += (wd_fired === 1'b1);
    end
    chk("kicks restart", n, 0);
    $display("watchdog test done");
  endtask : t_wdog
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    kick_en <= 1'b1;
    t_power();
    t_glitch();
    t_aux();
    t_mem();
    t_manual();
    t_wdog();
    print_verdict();
  end
endmodule : tb
